// ---- verilog/owc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module owc_top (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic fastCrystalInput,
  input wire logic slowCrystalInput,
  output logic fastOscRun,
  output logic slowOscRun,
  output logic pllRun,
  output logic pllOutputSelect,
  output logic warmupActiveFlag,
  output logic irq
);

  // ****************************************
  // declarations
  // ****************************************
  owc_pkg::owc_osc_ctrl_t ctrl_r;
  owc_pkg::owc_osc_ctrl_t ctrl_nxt;
  owc_pkg::owc_dphase_t dp_r;
  logic pll_output_select_r;
  logic [owc_pkg::EV_W-1:0] status_r;
  logic [owc_pkg::EV_W-1:0] mask_r;
  logic [owc_pkg::EV_W-1:0] evSet;
  logic [1:0] oscSync;
  logic [1:0] oscPrev_r;
  logic fastTick;
  logic slowTick;
  logic addrPhase;
  logic wrCtrl;
  logic wrPllSel;
  logic wrMask;
  logic rdStatus;
  logic rdLoad;
  logic startPulse;
  logic wuBusy;
  logic wuDone;
  logic [31:0] rdValue;

  // ****************************************
  // oscillator sampling
  // ****************************************
  owc_sync #(
    .W(2)
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .asyncIn({slowCrystalInput, fastCrystalInput}),
    .syncOut(oscSync)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      oscPrev_r <= 2'h0;
    end else begin
      oscPrev_r <= oscSync;
    end
  end

  assign fastTick = oscSync[0] & ~oscPrev_r[0];
  assign slowTick = oscSync[1] & ~oscPrev_r[1];

  // ****************************************
  // bus decode
  // ****************************************
  assign addrPhase = hsel & htrans[1] & hready;
  assign wrCtrl = dp_r.isWrite && dp_r.addr == owc_pkg::OFS_OSC_CTRL;
  assign wrPllSel = dp_r.isWrite && dp_r.addr == owc_pkg::OFS_PLL_SEL;
  assign wrMask = dp_r.isWrite && dp_r.addr == owc_pkg::OFS_IRQ_MASK;
  assign rdLoad = dp_r.isRead && !hreadyout;
  assign rdStatus = rdLoad && dp_r.addr == owc_pkg::OFS_IRQ_STATUS;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dp_r <= '0;
    end else if (addrPhase) begin
      dp_r.isWrite <= hwrite;
      dp_r.isRead <= ~hwrite;
      dp_r.addr <= haddr[owc_pkg::ADDR_DEC_W-1:0];
    end else if (hreadyout) begin
      dp_r <= '0;
    end
  end

  // ****************************************
  // control register write
  // ****************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wrCtrl) begin
      ctrl_nxt.pllRun = hwdata[owc_pkg::BIT_PLL_RUN];
      ctrl_nxt.clkSel = hwdata[owc_pkg::BIT_WU_CLKSEL];
      ctrl_nxt.lenSel = hwdata[owc_pkg::BIT_WU_LEN_LO +: 3];
      ctrl_nxt.fastRun = hwdata[owc_pkg::BIT_FAST_RUN];
      ctrl_nxt.slowRun = hwdata[owc_pkg::BIT_SLOW_RUN];
    end
  end

  assign startPulse = wrCtrl & hwdata[owc_pkg::BIT_WU_START];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= owc_pkg::OSC_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pll_output_select_r <= owc_pkg::PLL_OUTSEL_RST;
    end else if (wrPllSel) begin
      pll_output_select_r <= hwdata[owc_pkg::BIT_PLL_OUTSEL];
    end
  end

  // ****************************************
  // warm-up timer
  // ****************************************
  owc_warmup_counter #(
    .CNT_W(owc_pkg::WU_CNT_W)
  ) u_wu (
    .mclk(mclk),
    .reset_n(reset_n),
    .startPulse(startPulse),
    .lenCode(ctrl_nxt.lenSel),
    .clkSel(ctrl_nxt.clkSel),
    .fastTick(fastTick),
    .slowTick(slowTick),
    .busy(wuBusy),
    .donePulse(wuDone)
  );

  // ****************************************
  // pin outputs
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fastOscRun <= owc_pkg::OSC_CTRL_RST.fastRun;
      slowOscRun <= owc_pkg::OSC_CTRL_RST.slowRun;
      pllRun <= owc_pkg::OSC_CTRL_RST.pllRun;
      pllOutputSelect <= owc_pkg::PLL_OUTSEL_RST;
      warmupActiveFlag <= 1'b0;
    end else begin
      fastOscRun <= ctrl_r.fastRun;
      slowOscRun <= ctrl_r.slowRun;
      pllRun <= ctrl_r.pllRun;
      pllOutputSelect <= pll_output_select_r;
      warmupActiveFlag <= wuBusy;
    end
  end

  // ****************************************
  // events and interrupt
  // ****************************************
  always_comb begin
    evSet = '0;
    evSet[owc_pkg::BIT_EV_WU_DONE] = wuDone;
    evSet[owc_pkg::BIT_EV_PLL_MISUSE] = wrCtrl & ctrl_r.pllRun & ~ctrl_nxt.pllRun & pll_output_select_r;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= owc_pkg::EV_RST;
    end else if (rdStatus) begin
      status_r <= evSet;
    end else begin
      status_r <= status_r | evSet;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mask_r <= owc_pkg::MASK_RST;
    end else if (wrMask) begin
      mask_r <= hwdata[owc_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    rdValue = 32'h0000_0000;
    case (dp_r.addr)
      owc_pkg::OFS_OSC_CTRL: begin
        // start bit and unused bits read zero
        rdValue[owc_pkg::BIT_WU_ACTIVE] = wuBusy;
        rdValue[owc_pkg::BIT_PLL_RUN] = ctrl_r.pllRun;
        rdValue[owc_pkg::BIT_WU_CLKSEL] = ctrl_r.clkSel;
        rdValue[owc_pkg::BIT_WU_LEN_LO +: 3] = ctrl_r.lenSel;
        rdValue[owc_pkg::BIT_FAST_RUN] = ctrl_r.fastRun;
        rdValue[owc_pkg::BIT_SLOW_RUN] = ctrl_r.slowRun;
      end
      owc_pkg::OFS_PLL_SEL: begin
        rdValue[owc_pkg::BIT_PLL_OUTSEL] = pll_output_select_r;
      end
      owc_pkg::OFS_IRQ_STATUS: begin
        rdValue[owc_pkg::EV_W-1:0] = status_r;
      end
      owc_pkg::OFS_IRQ_MASK: begin
        rdValue[owc_pkg::EV_W-1:0] = mask_r;
      end
      default: begin
        rdValue = 32'h0000_0000;
      end
    endcase
  end

  // one wait state on reads, none on writes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hreadyout <= 1'b0;
    end else if (rdLoad) begin
      hreadyout <= 1'b1;
      hrdata <= rdValue;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_start_busy: assert property (@(posedge mclk) disable iff (!reset_n)
    startPulse && ctrl_nxt.lenSel != 3'h0 |=> wuBusy ##1 warmupActiveFlag)
    else $error("start did not raise the warm-up flag");

  a_start_reads0: assert property (@(posedge mclk) disable iff (!reset_n)
    rdLoad && dp_r.addr == owc_pkg::OFS_OSC_CTRL |=> hreadyout && !hrdata[0])
    else $error("start bit read back as one");

  a_busy_readback: assert property (@(posedge mclk) disable iff (!reset_n)
    rdLoad && dp_r.addr == owc_pkg::OFS_OSC_CTRL |=> hrdata[1] == $past(wuBusy))
    else $error("status bit does not show warm-up state");

  a_unused_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    rdLoad && dp_r.addr == owc_pkg::OFS_OSC_CTRL |=> hrdata[31:10] == 22'h0 && !hrdata[7])
    else $error("unused bit read as one");

  a_pll_write: assert property (@(posedge mclk) disable iff (!reset_n)
    wrCtrl |=> ##1 pllRun == $past(hwdata[2], 2))
    else $error("pll enable did not follow write");

  a_fast_osc: assert property (@(posedge mclk) disable iff (!reset_n)
    wrCtrl |=> ##1 fastOscRun == $past(hwdata[8], 2))
    else $error("fast oscillator enable did not follow write");

  a_slow_osc: assert property (@(posedge mclk) disable iff (!reset_n)
    wrCtrl |=> ##1 slowOscRun == $past(hwdata[9], 2))
    else $error("slow oscillator enable did not follow write");

  a_pll_held: assert property (@(posedge mclk) disable iff (!reset_n)
    !wrCtrl throughout (!ctrl_r.pllRun ##1 !ctrl_r.pllRun) |-> !pllRun)
    else $error("pll ran without a write");

  a_misuse_event: assert property (@(posedge mclk) disable iff (!reset_n)
    evSet[1] |=> status_r[1] ##1 (irq || !mask_r[1]))
    else $error("pll misuse not flagged");

  a_set_wins: assert property (@(posedge mclk) disable iff (!reset_n)
    rdStatus && wuDone |=> status_r[0])
    else $error("event lost on read clear");

  a_start_launch: assert property (@(posedge mclk) disable iff (!reset_n)
    startPulse |=> wuBusy || wuDone)
    else $error("start did not launch the warm-up");

  a_zero_no_start: assert property (@(posedge mclk) disable iff (!reset_n)
    !startPulse && !wuBusy |=> !wuBusy)
    else $error("warm-up began without a start");

  a_flag_clears: assert property (@(posedge mclk) disable iff (!reset_n)
    wuDone |=> !warmupActiveFlag)
    else $error("warm-up flag still set after completion");

  a_end_on_tick: assert property (@(posedge mclk) disable iff (!reset_n)
    wuBusy && !startPulse && !fastTick && !slowTick |=> wuBusy)
    else $error("warm-up ended without an oscillator edge");

  a_len_write: assert property (@(posedge mclk) disable iff (!reset_n)
    wrCtrl |=> ctrl_r.lenSel == $past(hwdata[6:4]) && ctrl_r.clkSel == $past(hwdata[3]))
    else $error("length or clock choice not taken from write");

  a_read_clears: assert property (@(posedge mclk) disable iff (!reset_n)
    rdStatus && !evSet[0] |=> !status_r[0])
    else $error("status read did not clear the done event");

  a_status_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
    !rdStatus |=> (status_r & $past(status_r)) == $past(status_r))
    else $error("status bit lost without a read");

  a_irq_level: assert property (@(posedge mclk) disable iff (!reset_n)
    |(status_r & mask_r) |=> irq)
    else $error("unmasked event did not raise the interrupt");

  a_mask_write: assert property (@(posedge mclk) disable iff (!reset_n)
    wrMask |=> mask_r == $past(hwdata[1:0]))
    else $error("mask did not follow write");

  a_pll_output_select_write: assert property (@(posedge mclk) disable iff (!reset_n)
    wrPllSel |=> pll_output_select_r == $past(hwdata[0]))
    else $error("pll output select did not follow write");

endmodule
`default_nettype wire

// ---- inc/owc_pkg.sv ----
package owc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] OFS_OSC_CTRL = 12'h204;
  localparam logic [11:0] OFS_PLL_SEL = 12'h20C;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h220;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h224;
  localparam int ADDR_DEC_W = 12;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_WU_START = 0;
  localparam int BIT_WU_ACTIVE = 1;
  localparam int BIT_PLL_RUN = 2;
  localparam int BIT_WU_CLKSEL = 3;
  localparam int BIT_WU_LEN_LO = 4;
  localparam int BIT_FAST_RUN = 8;
  localparam int BIT_SLOW_RUN = 9;
  localparam int BIT_PLL_OUTSEL = 0;
  localparam int BIT_EV_WU_DONE = 0;
  localparam int BIT_EV_PLL_MISUSE = 1;
  localparam int EV_W = 2;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [2:0] WU_LEN_NONE = 3'h0;
  localparam int FAST_EXP_BASE = 9;
  localparam int SLOW_EXP_BASE = 5;
  localparam int WU_CNT_W = 17;
  localparam logic [EV_W-1:0] EV_RST = 2'h0;
  localparam logic [EV_W-1:0] MASK_RST = 2'h0;
  localparam logic PLL_OUTSEL_RST = 1'h0;

  typedef struct packed {
    logic slowRun;
    logic fastRun;
    logic [2:0] lenSel;
    logic clkSel;
    logic pllRun;
  } owc_osc_ctrl_t;

  localparam owc_osc_ctrl_t OSC_CTRL_RST = 7'h64;

  typedef struct packed {
    logic isWrite;
    logic isRead;
    logic [ADDR_DEC_W-1:0] addr;
  } owc_dphase_t;

  // last count value for a length code and oscillator choice
  function automatic logic [WU_CNT_W-1:0] lastCount(input logic [2:0] code, input logic sel);
    int e;
    e = (sel ? SLOW_EXP_BASE : FAST_EXP_BASE) + int'(code);
    return WU_CNT_W'((32'h1 << e) - 32'h1);
  endfunction

endpackage

// ---- verilog/owc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module owc_sync #(
  parameter int W = 2
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] meta_r;

  // ****************************************
  // two flop synchroniser
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      syncOut <= '0;
    end else begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ---- verilog/owc_warmup_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module owc_warmup_counter #(
  parameter int CNT_W = owc_pkg::WU_CNT_W
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic startPulse,
  input wire logic [2:0] lenCode,
  input wire logic clkSel,
  input wire logic fastTick,
  input wire logic slowTick,
  output logic busy,
  output logic donePulse
);

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] last_r;
  logic sel_r;
  logic tick;

  assign tick = sel_r ? slowTick : fastTick;

  // ****************************************
  // warm-up count
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
      last_r <= '0;
      sel_r <= 1'b0;
      busy <= 1'b0;
      donePulse <= 1'b0;
    end else begin
      donePulse <= 1'b0;
      if (startPulse) begin
        count_r <= '0;
        sel_r <= clkSel;
        last_r <= CNT_W'(owc_pkg::lastCount(lenCode, clkSel));
        busy <= (lenCode != owc_pkg::WU_LEN_NONE);
        donePulse <= (lenCode == owc_pkg::WU_LEN_NONE);
      end else if (busy && tick) begin
        if (count_r == last_r) begin
          busy <= 1'b0;
          donePulse <= 1'b1;
        end else begin
          count_r <= count_r + CNT_W'(1);
        end
      end
    end
  end

  a_code_none: assert property (@(posedge mclk) disable iff (!reset_n)
    startPulse && lenCode == owc_pkg::WU_LEN_NONE |=> !busy && donePulse)
    else $error("zero length warm-up did not finish at once");

  a_restart_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    startPulse && lenCode != owc_pkg::WU_LEN_NONE |=> busy && count_r == '0)
    else $error("warm-up did not restart from zero");

  a_done_at_last: assert property (@(posedge mclk) disable iff (!reset_n)
    busy && tick && !startPulse && count_r == last_r |=> !busy && donePulse)
    else $error("warm-up did not end at its last count");

  a_fast_length: assert property (@(posedge mclk) disable iff (!reset_n)
    startPulse && !clkSel && lenCode == 3'h1 |=> last_r == CNT_W'(17'h003FF))
    else $error("fast code 001 is not 2^10 cycles");

endmodule
`default_nettype wire

// ---- testbench/tb_oscillator_warmup_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_oscillator_warmup_control;
  // ****************************************
  // signals and clocks
  // ****************************************
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] rdN;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic rdyN;
  logic fastCrystalInput = 1'b0;
  logic slowCrystalInput = 1'b0;
  logic fastOscRun;
  logic slowOscRun;
  logic pllRun;
  logic pllOutputSelect;
  logic warmupActiveFlag;
  logic irq;
  logic [2:0] divCnt = 3'h0;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  assign hready = hreadyout;
  always #2.5 mclk = ~mclk;

  owc_top owc_top_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .fastCrystalInput(fastCrystalInput),
    .slowCrystalInput(slowCrystalInput),
    .fastOscRun(fastOscRun),
    .slowOscRun(slowOscRun),
    .pllRun(pllRun),
    .pllOutputSelect(pllOutputSelect),
    .warmupActiveFlag(warmupActiveFlag),
    .irq(irq)
  );

  // crystals at mclk/4 and mclk/8, plus the hang limit
  always @(posedge mclk) begin
    divCnt <= divCnt + 3'h1;
    fastCrystalInput <= divCnt[1];
    slowCrystalInput <= divCnt[2];
    cycles = cycles + 1;
    if (cycles > 60000) begin
      failures = failures + 1;
      give_verdict();
    end
  end

  // registered outputs sampled mid-cycle stand for the next rising edge
  always @(negedge mclk) begin
    rdyN = hreadyout;
    rdN = hrdata;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic busXfer(input logic isWr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h40040, a};
    htrans <= 2'h2;
    hwrite <= isWr;
    do @(posedge mclk); while (rdyN !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (rdyN !== 1'b1);
    rd = rdN;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    busXfer(1'b1, a, d);
  endtask

  task automatic rdChk(input string name, input logic [11:0] a, input logic [31:0] exp);
    busXfer(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  // pins as {fast, slow, pllRun, pll_output_select, flag, irq}
  task automatic pinChk(input logic [31:0] exp);
    repeat (3) @(posedge mclk);
    check("pins", {26'h0, fastOscRun, slowOscRun, pllRun, pllOutputSelect, warmupActiveFlag, irq}, exp);
  endtask

  task automatic edges(input int n, input logic slow);
    if (slow) begin
      repeat (n) @(posedge slowCrystalInput);
    end else begin
      repeat (n) @(posedge fastCrystalInput);
    end
  endtask

  // one warm-up run with the done event unmasked
  task automatic wu(input logic [31:0] ctl, input int n);
    wr(12'h204, ctl);
    rdChk("oscCtrl", 12'h204, ctl ^ 32'h3);
    edges(n - 6, ctl[3]);
    check("flag", {31'h0, warmupActiveFlag}, 32'h1);
    edges(8, ctl[3]);
    repeat (8) @(posedge mclk);
    check("flag", {31'h0, warmupActiveFlag}, 32'h0);
    check("irq", {31'h0, irq}, 32'h1);
    rdChk("oscCtrl", 12'h204, ctl ^ 32'h1);
    rdChk("status", 12'h220, 32'h1);
    pinChk(32'h30);
    $display("test warmup %h done", ctl);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    pinChk(32'h30);
    rdChk("oscCtrl", 12'h204, 32'h310);
    rdChk("pll_output_select", 12'h20C, 32'h0);
    $display("test reset done");

    wr(12'h204, 32'hFFFFFFFE);
    rdChk("oscCtrl", 12'h204, 32'h37C);
    pinChk(32'h38);
    wr(12'h204, 32'h0);
    rdChk("oscCtrl", 12'h204, 32'h0);
    pinChk(32'h0);
    wr(12'h100, 32'hFFFFFFFF);
    rdChk("unmapped", 12'h100, 32'h0);
    $display("test access done");

    wr(12'h224, 32'h0);
    wr(12'h204, 32'h309);
    pinChk(32'h30);
    rdChk("status", 12'h220, 32'h1);
    rdChk("status", 12'h220, 32'h0);
    $display("test no warmup done");

    wr(12'h224, 32'h1);
    wu(32'h311, 1024);
    wu(32'h319, 64);
    wu(32'h379, 4096);

    wr(12'h204, 32'h319);
    edges(30, 1'b1);
    wr(12'h204, 32'h319);
    edges(50, 1'b1);
    check("flag", {31'h0, warmupActiveFlag}, 32'h1);
    edges(22, 1'b1);
    repeat (8) @(posedge mclk);
    check("flag", {31'h0, warmupActiveFlag}, 32'h0);
    rdChk("status", 12'h220, 32'h1);
    $display("test restart done");

    wr(12'h224, 32'h2);
    wr(12'h204, 32'h304);
    wr(12'h20C, 32'h1);
    rdChk("pll_output_select", 12'h20C, 32'h1);
    pinChk(32'h3C);
    wr(12'h204, 32'h300);
    pinChk(32'h35);
    rdChk("status", 12'h220, 32'h2);
    pinChk(32'h34);
    wr(12'h204, 32'h304);
    wr(12'h20C, 32'h0);
    rdChk("pll_output_select", 12'h20C, 32'h0);
    wr(12'h204, 32'h300);
    rdChk("status", 12'h220, 32'h0);
    pinChk(32'h30);
    $display("test pll done");

    wr(12'h204, 32'h37C);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    pinChk(32'h30);
    rdChk("oscCtrl", 12'h204, 32'h310);
    $display("test second reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
